// file: verilog/rip_pkg.sv
// shared constants and types for the regulator register port link
package rip_pkg;
  localparam logic [6:0] TGT_ADDR = 7'h28;
  localparam logic [7:0] REG_ID = 8'h00;
  localparam logic [7:0] REG_CFGA = 8'h01;
  localparam logic [7:0] REG_VOUT = 8'h02;
  localparam logic [7:0] REG_PEAK = 8'h03;
  localparam logic [7:0] REG_CFGB = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h05;
  localparam logic [7:0] REG_INT = 8'h06;
  localparam logic [7:0] REG_MASK = 8'h07;
  localparam logic [7:0] REG_LOCK_EXEMPTION = 8'h50;
  localparam logic [7:0] REG_LOCK_CODE = 8'h51;
  localparam logic [7:0] RST_CFGA = 8'h13;
  localparam logic [7:0] RST_VOUT = 8'hCE;
  localparam logic [7:0] RST_PEAK = 8'h84;
  localparam logic [7:0] RST_CFGB = 8'h01;
  localparam logic [1:0] RST_MASK = 2'h3;
  localparam logic RST_LOCK_EXEMPTION = 1'b1;
  localparam logic [7:0] RST_LOCK_CODE = 8'hFF;
  localparam int CFGA_EN = 7;
  localparam int CFGA_ZCC = 4;
  localparam int CFGA_TOPO = 2;
  localparam int CFGB_INTEG = 2;
  localparam int CFGB_FET = 0;
  localparam logic [7:0] CFGB_WMASK = 8'hE7;
  localparam logic [7:0] VOUT_CODE_MASK = 8'h3F;
  localparam logic [7:0] LOCK_CODE_LOCK = 8'hAA;
  localparam logic [7:0] LOCK_CODE_UNLOCK = 8'h55;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int SCL_MIN_PERIOD_NS = 2500;
  localparam int QUARTER_CYC = (SCL_MIN_PERIOD_NS / 4 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  typedef enum logic [4:0] {
    T_IDLE = 5'b00001, T_DEV = 5'b00010, T_REG = 5'b00100, T_WR = 5'b01000, T_RD = 5'b10000
  } rip_tstate_e;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_START = 4'b0010, H_BIT = 4'b0100, H_STOP = 4'b1000
  } rip_hstate_e;
  typedef enum logic [4:0] {
    P_DEVW = 5'b00001, P_REG = 5'b00010, P_WDATA = 5'b00100, P_DEVR = 5'b01000,
    P_RDATA = 5'b10000
  } rip_step_e;
endpackage

// file: verilog/rip_link_if.sv
// two-wire link between controller and target, open-drain wired-and
interface rip_link_if;
  logic hostSclO;
  logic hostSclOe;
  logic hostSdaO;
  logic hostSdaOe;
  logic tgtSdaO;
  logic tgtSdaOe;
  logic scl;
  logic sda;
  assign scl = !(hostSclOe && !hostSclO);
  assign sda = !(hostSdaOe && !hostSdaO) && !(tgtSdaOe && !tgtSdaO);
  modport target(input scl, input sda, output tgtSdaO, output tgtSdaOe);
  modport controller(input scl, input sda, output hostSclO, output hostSclOe,
                     output hostSdaO, output hostSdaOe);
endinterface

// file: verilog/rip_target.sv
// target end: two-wire register port of the regulator
module rip_target
  import rip_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A  // arbitrary identity value
) (
  input wire logic mclk,             // system clock
  input wire logic rst,              // async reset, active high
  rip_link_if.target link,           // two-wire link
  input wire logic outputOkIn,       // analog output-good status
  input wire logic inputLowIn,       // analog input-undervoltage status
  output logic [7:0] configA,        // first config register
  output logic [7:0] voutSetting,    // output voltage register
  output logic [7:0] peakCurrent,    // peak current register
  output logic [7:0] configB,        // second config register
  output logic zccLatched,           // latched zero-crossing disable
  output logic topologyLatched,      // latched operating mode
  output logic integratorLatched,    // latched integrator enable
  output logic halfScaleLatched,     // latched switch scaling
  output logic voutLocked,           // voltage code locked
  output logic irqPending            // unmasked flag pending
);
  ////////////////////////////////////////////////////////////////////////
  // synchronisers: stage 0 feeds only stage 1, stage 2 is previous value
  logic [2:0] sclSy_q;
  logic [2:0] sdaSy_q;
  logic [2:0] okSy_q;
  logic [2:0] lowSy_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclSy_q <= 3'h7;
      sdaSy_q <= 3'h7;
      okSy_q <= 3'h0;
      lowSy_q <= 3'h0;
    end else begin
      sclSy_q <= {sclSy_q[1:0], link.scl};
      sdaSy_q <= {sdaSy_q[1:0], link.sda};
      okSy_q <= {okSy_q[1:0], outputOkIn};
      lowSy_q <= {lowSy_q[1:0], inputLowIn};
    end
  end
  wire sdaIn = sdaSy_q[1];
  wire sclRise = sclSy_q[1] && !sclSy_q[2];
  wire sclFall = !sclSy_q[1] && sclSy_q[2];
  wire sclSteady = sclSy_q[1] && sclSy_q[2];
  wire startC = sclSteady && sdaSy_q[2] && !sdaSy_q[1];
  wire stopC = sclSteady && !sdaSy_q[2] && sdaSy_q[1];

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [1:0] status;
  logic [1:0] flags_q;
  logic [1:0] mask_q;
  logic lockExempt_q;
  logic [7:0] lock_code_q;

  function automatic logic regValid(input logic [7:0] a);
    regValid = (a <= REG_MASK) || (a == REG_LOCK_EXEMPTION) || (a == REG_LOCK_CODE);
  endfunction

  function automatic logic [7:0] nextPtr(input logic [7:0] a);
    nextPtr = (a == REG_ID) ? a : 8'(a + 8'h01);
  endfunction

  // contents come in as arguments so the read path follows every write
  function automatic logic [7:0] readReg(input logic [7:0] a, input logic [63:0] low,
                                         input logic [15:0] lk);
    if (a <= REG_MASK) readReg = low[{a[2:0], 3'b000} +: 8];
    else if (a == REG_LOCK_EXEMPTION) readReg = lk[7:0];
    else if (a == REG_LOCK_CODE) readReg = lk[15:8];
    else readReg = 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  rip_tstate_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic sdaOe_q;
  logic sdaO_q;

  wire ninthRise = sclRise && (cnt_q == ACK_BIT);
  wire byteFall = sclFall && (cnt_q == ACK_BIT);
  wire ctrl = startC || stopC;
  wire hostAck = !sdaIn;
  wire rdNext = (st_q == T_RD) && hostAck;
  wire rdLoad = !ctrl && ninthRise && (((st_q == T_DEV) && sdaOe_q && rw_q) || rdNext);
  wire [7:0] rdAddr = rdNext ? nextPtr(ptr_q) : ptr_q;
  wire [63:0] lowRegs = {6'h00, mask_q, 6'h00, flags_q, 6'h00, status, configB, peakCurrent,
    voutSetting, configA, CHIP_ID};
  wire [15:0] lockRegs = {lock_code_q, 7'h00, lockExempt_q};
  wire [7:0] rdByte = readReg(rdAddr, lowRegs, lockRegs);
  wire addrHit = (shift_q[7:1] == TGT_ADDR);
  wire wrEn = !ctrl && byteFall && (st_q == T_WR) && regValid(ptr_q);
  wire intClr = rdLoad && (rdAddr == REG_INT);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= T_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      sdaOe_q <= 1'b0;
    end else if (startC) begin
      st_q <= T_DEV;  // repeated start restarts here too
      cnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
    end else if (stopC) begin
      st_q <= T_IDLE;
      cnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
    end else if (sclRise && (st_q != T_IDLE)) begin
      if (cnt_q == ACK_BIT) begin
        cnt_q <= 4'h0;
        if (rdLoad) shift_q <= rdByte;
        if (rdNext) ptr_q <= rdAddr;
        case (st_q)
          T_DEV: st_q <= !sdaOe_q ? T_IDLE : (rw_q ? T_RD : T_REG);
          T_REG: st_q <= sdaOe_q ? T_WR : T_IDLE;
          T_WR: st_q <= sdaOe_q ? T_WR : T_IDLE;
          T_RD: st_q <= hostAck ? T_RD : T_IDLE;
          default: st_q <= T_IDLE;
        endcase
      end else begin
        cnt_q <= 4'(cnt_q + 4'h1);
        shift_q <= (st_q == T_RD) ? {shift_q[6:0], 1'b0} : {shift_q[6:0], sdaIn};
      end
    end else if (sclFall && (st_q != T_IDLE)) begin
      if (cnt_q == ACK_BIT) begin
        case (st_q)
          T_DEV: begin
            sdaOe_q <= addrHit;
            rw_q <= shift_q[0];
          end
          T_REG: begin
            sdaOe_q <= regValid(shift_q);
            ptr_q <= shift_q;
          end
          T_WR: begin
            sdaOe_q <= regValid(ptr_q);
            ptr_q <= nextPtr(ptr_q);
          end
          default: sdaOe_q <= 1'b0;  // host drives its ack
        endcase
      end else begin
        // data changes only while clock is low
        sdaOe_q <= (st_q == T_RD) && !shift_q[7];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) sdaO_q <= 1'b0;
    else sdaO_q <= 1'b0;  // open drain: only ever pulls low
  end
  assign link.tgtSdaOe = sdaOe_q;
  assign link.tgtSdaO = sdaO_q;

  ////////////////////////////////////////////////////////////////////////
  // register writes
  wire [7:0] wrData = shift_q;
  wire pwWrite = wrEn && (ptr_q == REG_LOCK_CODE) && !lockExempt_q;
  wire [7:0] voutKeep = voutLocked ? (voutSetting & VOUT_CODE_MASK) : (wrData & VOUT_CODE_MASK);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      configA <= RST_CFGA;
      voutSetting <= RST_VOUT;
      peakCurrent <= RST_PEAK;
      configB <= RST_CFGB;
      mask_q <= RST_MASK;
      lockExempt_q <= RST_LOCK_EXEMPTION;
      lock_code_q <= RST_LOCK_CODE;
    end else if (wrEn) begin
      case (ptr_q)
        REG_CFGA: configA <= wrData;
        REG_VOUT: voutSetting <= (wrData & ~VOUT_CODE_MASK) | voutKeep;
        REG_PEAK: peakCurrent <= wrData;
        REG_CFGB: configB <= wrData & CFGB_WMASK;
        REG_MASK: mask_q <= wrData[1:0];
        REG_LOCK_EXEMPTION: lockExempt_q <= wrData[0];
        REG_LOCK_CODE: lock_code_q <= wrData;
        default: ;  // identity and read-only registers keep their value
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) voutLocked <= 1'b0;
    else if (pwWrite && (wrData == LOCK_CODE_LOCK)) voutLocked <= 1'b1;
    else if (pwWrite && (wrData == LOCK_CODE_UNLOCK)) voutLocked <= 1'b0;
  end

  // mode copies freeze while running so a write cannot disturb the loop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zccLatched <= RST_CFGA[CFGA_ZCC];
      topologyLatched <= RST_CFGA[CFGA_TOPO];
      integratorLatched <= RST_CFGB[CFGB_INTEG];
      halfScaleLatched <= RST_CFGB[CFGB_FET];
    end else if (!configA[CFGA_EN]) begin
      zccLatched <= configA[CFGA_ZCC];
      topologyLatched <= configA[CFGA_TOPO];
      integratorLatched <= configB[CFGB_INTEG];
      halfScaleLatched <= configB[CFGB_FET];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live status and change flags, the flags cleared when read; a change wins over clear
  assign status = {okSy_q[1], lowSy_q[1]};
  wire [1:0] change = {okSy_q[1] ^ okSy_q[2], lowSy_q[1] ^ lowSy_q[2]};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_q <= 2'h0;
      irqPending <= 1'b0;
    end else begin
      flags_q <= (intClr ? 2'h0 : flags_q) | change;
      irqPending <= |(flags_q & ~mask_q);
    end
  end
endmodule

// file: verilog/rip_controller.sv
// controller end: drives the clock and runs register reads and writes
module rip_controller
  import rip_pkg::*;
(
  input wire logic mclk,          // system clock
  input wire logic rst,           // async reset, active high
  rip_link_if.controller link,    // two-wire link
  input wire logic cmdValid,      // start a transfer when ready
  input wire logic cmdRead,       // 1 read, 0 write
  input wire logic [7:0] cmdReg,  // register address
  input wire logic [3:0] cmdCount,  // data bytes, 1 to 15
  input wire logic [7:0] wrData,  // next write byte, taken on wrTake
  output logic cmdReady,          // idle, command accepted
  output logic wrTake,            // wrData sampled this cycle
  output logic [7:0] rdData,      // read byte
  output logic rdValid,           // rdData new this cycle
  output logic done,              // transfer finished
  output logic nackSeen           // target refused a byte
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] sdaSy_q;
  rip_hstate_e st_q;
  rip_step_e step_q;
  logic [1:0] phase_q;
  logic [7:0] qcnt_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [7:0] rx_q;
  logic [3:0] left_q;
  logic readOp_q;
  logic sclOe_q;
  logic sdaOe_q;
  logic lowO_q;

  wire tick = (st_q != H_IDLE) && (qcnt_q == 8'(QUARTER_CYC - 1));
  wire symEnd = tick && (phase_q == 2'h3);
  wire ack = !sdaSy_q[1];
  wire lastRd = (left_q == 4'h1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdaSy_q <= 2'h3;
      lowO_q <= 1'b0;
    end else begin
      sdaSy_q <= {sdaSy_q[0], link.sda};
      lowO_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= H_IDLE;
      step_q <= P_DEVW;
      phase_q <= 2'h0;
      qcnt_q <= 8'h00;
      bit_q <= 4'h0;
      tx_q <= 9'h1FF;
      rx_q <= 8'h00;
      left_q <= 4'h0;
      readOp_q <= 1'b0;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      cmdReady <= 1'b0;
      wrTake <= 1'b0;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      done <= 1'b0;
      nackSeen <= 1'b0;
    end else begin
      wrTake <= 1'b0;
      rdValid <= 1'b0;
      done <= 1'b0;
      cmdReady <= (st_q == H_IDLE) && !cmdValid;
      qcnt_q <= tick || (st_q == H_IDLE) ? 8'h00 : 8'(qcnt_q + 8'h01);
      if (tick) phase_q <= 2'(phase_q + 2'h1);
      if ((st_q == H_IDLE) && cmdValid) begin
        st_q <= H_START;
        step_q <= P_DEVW;
        phase_q <= 2'h0;
        tx_q <= {TGT_ADDR, 1'b0, 1'b1};
        readOp_q <= cmdRead;
        left_q <= cmdCount;
        nackSeen <= 1'b0;
        sclOe_q <= 1'b1;
      end else if (tick && (phase_q == 2'h0)) begin
        // sda moves only a quarter after the clock went low
        if (st_q == H_BIT) sdaOe_q <= !tx_q[8];
        else sdaOe_q <= (st_q == H_STOP);
      end else if (tick && (phase_q == 2'h1)) begin
        sclOe_q <= 1'b0;
      end else if (tick && (phase_q == 2'h2)) begin
        if (st_q == H_START) sdaOe_q <= 1'b1;
        if (st_q == H_STOP) sdaOe_q <= 1'b0;
      end else if (symEnd) begin
        sclOe_q <= (st_q != H_STOP);
        case (st_q)
          H_START: begin
            st_q <= H_BIT;
            bit_q <= 4'h0;
          end
          H_STOP: begin
            st_q <= H_IDLE;
            done <= 1'b1;
          end
          H_BIT: begin
            if (bit_q != ACK_BIT) begin
              rx_q <= {rx_q[6:0], sdaSy_q[1]};
              tx_q <= {tx_q[7:0], 1'b1};
              bit_q <= 4'(bit_q + 4'h1);
            end else begin
              bit_q <= 4'h0;
              case (step_q)
                P_DEVW: begin
                  step_q <= P_REG;
                  tx_q <= {cmdReg, 1'b1};
                  st_q <= ack ? H_BIT : H_STOP;
                  nackSeen <= !ack;
                end
                P_REG: begin
                  nackSeen <= !ack;
                  if (!ack) st_q <= H_STOP;
                  else if (readOp_q) begin
                    step_q <= P_DEVR;
                    st_q <= H_START;
                    tx_q <= {TGT_ADDR, 1'b1, 1'b1};
                  end else begin
                    step_q <= P_WDATA;
                    tx_q <= {wrData, 1'b1};
                    wrTake <= 1'b1;
                  end
                end
                P_WDATA: begin
                  nackSeen <= !ack;
                  left_q <= 4'(left_q - 4'h1);
                  if (!ack || lastRd) st_q <= H_STOP;
                  else begin
                    tx_q <= {wrData, 1'b1};
                    wrTake <= 1'b1;
                  end
                end
                P_DEVR: begin
                  nackSeen <= !ack;
                  step_q <= P_RDATA;
                  tx_q <= {8'hFF, lastRd};
                  st_q <= ack ? H_BIT : H_STOP;
                end
                default: begin
                  rdData <= rx_q;
                  rdValid <= 1'b1;
                  left_q <= 4'(left_q - 4'h1);
                  tx_q <= {8'hFF, (left_q == 4'h2)};
                  if (lastRd) st_q <= H_STOP;
                end
              endcase
            end
          end
          default: st_q <= H_IDLE;
        endcase
      end
    end
  end
  assign link.hostSclOe = sclOe_q;
  assign link.hostSclO = lowO_q;
  assign link.hostSdaOe = sdaOe_q;
  assign link.hostSdaO = lowO_q;
endmodule

// file: testbench/rip_link_monitor.sv
// concurrent checks on the two-wire link between controller and target
module rip_link_monitor (
  input wire logic mclk,       // system clock
  input wire logic rst,        // async reset, active high
  input wire logic hostSclOe,  // controller pulls clock low
  input wire logic hostSdaOe,  // controller pulls data low
  input wire logic tgtSdaOe,   // target pulls data low
  input wire logic scl,        // resolved clock level
  input wire logic sda         // resolved data level
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  // cycles since the last clock rise; saturates at a stop so idle gaps are skipped
  logic [9:0] perCnt_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      perCnt_q <= 10'h3FF;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= scl;
      sdaPrev_q <= sda;
      if (scl && sclPrev_q && sda && !sdaPrev_q) perCnt_q <= 10'h3FF;
      else if (scl && !sclPrev_q) perCnt_q <= 10'h001;
      else if (perCnt_q != 10'h3FF) perCnt_q <= perCnt_q + 10'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_held(sig);
    sig [*8];
  endsequence
  sequence s_clk_up;
    $rose(scl);
  endsequence

  // 250 and 714 cycles bound the clock period between 400kHz and 140kHz
  a_clock_rate: assert property (scl && !sclPrev_q && perCnt_q != 10'h3FF |->
    perCnt_q >= 10'h0FA && perCnt_q <= 10'h2CA) else $error("clock period out of range");
  a_idle_released: assert property (scl && $rose(sda) |->
    (!hostSclOe && !hostSdaOe && !tgtSdaOe) [*3]) else $error("line pulled after stop");
  a_tgt_ack_hold: assert property (s_clk_up and tgtSdaOe |-> s_held(tgtSdaOe))
    else $error("target let data go during clock high");
  a_host_low_hold: assert property (s_clk_up and hostSdaOe |-> s_held(hostSdaOe))
    else $error("controller let data go during clock high");
  a_nack_released: assert property (s_clk_up and sda |-> s_held(sda))
    else $error("data pulled during released clock pulse");
  a_tgt_stable_high: assert property (scl && $past(scl) |-> $stable(tgtSdaOe))
    else $error("target data changed while clock high");
  a_tgt_drive_low: assert property ($rose(tgtSdaOe) |-> !scl)
    else $error("target began pulling data while clock high");
  a_start_by_host: assert property (scl && $fell(sda) |-> hostSdaOe && !tgtSdaOe)
    else $error("start condition not made by controller");
endmodule

// file: testbench/tb.sv
// self-checking bench: controller and target joined over the two-wire link
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_VAL = 8'h3C;  // arbitrary identity value
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdRead = 1'b0;
  logic [7:0] cmdReg = 8'h00;
  logic [3:0] cmdCount = 4'h1;
  logic [7:0] wrData = 8'h00;
  logic outputOkIn = 1'b0;
  logic inputLowIn = 1'b0;
  logic cmdReady, wrTake, rdValid, done, nackSeen, voutLocked, irqPending;
  logic zccLatched, topologyLatched, integratorLatched, halfScaleLatched, ack;
  logic [7:0] rdData, configA, voutSetting, peakCurrent, configB;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;

  rip_link_if link();
  rip_link_if link2();
  always #5 mclk = ~mclk;

  rip_target #(.CHIP_ID(ID_VAL)) u_rip_target (.mclk(mclk), .rst(rst), .link(link),
    .outputOkIn(outputOkIn), .inputLowIn(inputLowIn), .configA(configA),
    .voutSetting(voutSetting), .peakCurrent(peakCurrent), .configB(configB),
    .zccLatched(zccLatched), .topologyLatched(topologyLatched),
    .integratorLatched(integratorLatched),
    .halfScaleLatched(halfScaleLatched), .voutLocked(voutLocked), .irqPending(irqPending));
  rip_controller u_rip_controller (.mclk(mclk), .rst(rst), .link(link), .cmdValid(cmdValid),
    .cmdRead(cmdRead), .cmdReg(cmdReg), .cmdCount(cmdCount), .wrData(wrData),
    .cmdReady(cmdReady), .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .done(done),
    .nackSeen(nackSeen));
  // second target faces a bench driver that addresses it wrongly, then correctly
  rip_target u_rip_target_b (.mclk(mclk), .rst(rst), .link(link2), .outputOkIn(1'b0),
    .inputLowIn(1'b0), .configA(), .voutSetting(), .peakCurrent(), .configB(), .zccLatched(),
    .topologyLatched(), .integratorLatched(), .halfScaleLatched(), .voutLocked(),
    .irqPending());
  rip_link_monitor u_rip_link_monitor (.mclk(mclk), .rst(rst), .hostSclOe(link.hostSclOe),
    .hostSdaOe(link.hostSdaOe), .tgtSdaOe(link.tgtSdaOe), .scl(link.scl), .sda(link.sda));

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chkq(input logic [7:0] e[$]);
    chk(8'(rq.size()), 8'(e.size()));
    foreach (e[i]) chk(rq[i], e[i]);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 100000) begin
      miscompares++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // one command; write bytes come from wq, read bytes land in rq
  task automatic xfer(input logic rd, input logic [7:0] r, input int n, input logic nk);
    int w;
    logic took;
    w = 0;
    took = 1'b0;
    rq = {};
    @(posedge mclk);
    #1;
    chk({7'h00, cmdReady}, 8'h01);
    cmdValid = 1'b1;
    cmdRead = rd;
    cmdReg = r;
    cmdCount = n[3:0];
    wrData = (wq.size() > 0) ? wq[0] : 8'h00;
    @(posedge mclk);
    #1;
    cmdValid = 1'b0;
    // a hang is caught by the cycle ceiling, not here
    while (done !== 1'b1) begin
      @(posedge mclk);
      #1;
      // advance only after the edge that used the byte
      if (took) begin
        w++;
        if (w < wq.size()) wrData = wq[w];
      end
      took = (wrTake === 1'b1);
      if (rdValid === 1'b1) rq.push_back(rdData);
    end
    chk({7'h00, nackSeen}, {7'h00, nk});
  endtask

  // raw link driver: c pulls clock low, d pulls data low, for one quarter of 125 ns
  task automatic lv(input logic c, input logic d);
    link2.hostSclOe = c;
    link2.hostSdaOe = d;
    #31.25;
  endtask

  task automatic bang(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      lv(1'b1, link2.hostSdaOe);
      lv(1'b1, !b[i]);
      lv(1'b0, !b[i]);
      lv(1'b0, !b[i]);
    end
    lv(1'b1, link2.hostSdaOe);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
    a = !link2.sda;
    lv(1'b0, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    link2.hostSclO = 1'b0;
    link2.hostSdaO = 1'b0;
    link2.hostSclOe = 1'b0;
    link2.hostSdaOe = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    xfer(1'b1, 8'h01, 6, 1'b0);
    chkq('{8'h13, 8'hCE, 8'h84, 8'h01, 8'h00, 8'h00});
    wq = '{8'h77, 8'h66};
    xfer(1'b0, 8'h00, 2, 1'b0);
    chk(configA, 8'h13);
    xfer(1'b1, 8'h00, 2, 1'b0);
    chkq('{ID_VAL, ID_VAL});
    // enable first, so the later mode bits must not reach the latched copies
    wq = '{8'h87, 8'h41, 8'h95, 8'h24};
    xfer(1'b0, 8'h01, 4, 1'b0);
    chk(configA, 8'h87);
    chk({7'h00, zccLatched}, 8'h01);
    chk({7'h00, topologyLatched}, 8'h00);
    chk(voutSetting, 8'h41);
    chk(peakCurrent, 8'h95);
    chk(configB, 8'h24);
    chk({7'h00, integratorLatched}, 8'h00);
    chk({7'h00, halfScaleLatched}, 8'h01);
    wq = '{8'h00};
    xfer(1'b0, 8'h08, 1, 1'b1);
    wq = '{8'h00, 8'hAA};
    xfer(1'b0, 8'h50, 2, 1'b0);
    chk({7'h00, voutLocked}, 8'h01);
    wq = '{8'h00};
    xfer(1'b0, 8'h02, 1, 1'b0);
    chk(voutSetting, 8'h01);
    @(posedge mclk);
    #1;
    outputOkIn = 1'b1;
    inputLowIn = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk({7'h00, irqPending}, 8'h00);
    wq = '{8'h01};
    xfer(1'b0, 8'h07, 1, 1'b0);
    chk({7'h00, irqPending}, 8'h01);
    xfer(1'b1, 8'h05, 2, 1'b0);
    chkq('{8'h03, 8'h03});
    repeat (4) @(posedge mclk);
    #1;
    chk({7'h00, irqPending}, 8'h00);
    // wrong address first, then the right one to prove the driver works
    for (int k = 0; k < 2; k++) begin
      lv(1'b0, 1'b0);
      lv(1'b0, 1'b1);
      bang((k == 0) ? 8'h52 : 8'h50, ack);
      chk({7'h00, ack}, k[7:0]);
      lv(1'b1, 1'b0);
      lv(1'b1, 1'b1);
      lv(1'b0, 1'b1);
      lv(1'b0, 1'b0);
    end
    final_report();
  end
endmodule
